// [logic/pcrs_pkg.sv]
// constants, commands and carriers shared by the counter and return stack
package pcrs_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int PCRS_PC_W    = 21;   // byte address width of the counter
   localparam int PCRS_PTR_W   = 5;    // stack pointer width
   localparam int PCRS_DEPTH   = 31;   // stack entries, index 1 to 31
   localparam int PCRS_ADDR_W  = 8;    // register bus address width
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] PCRS_OFS_COUNTER_LOW  = 8'h00;
   localparam logic [7:0] PCRS_OFS_HIGH_LATCH   = 8'h04;
   localparam logic [7:0] PCRS_OFS_UPPER_LATCH  = 8'h08;
   localparam logic [7:0] PCRS_OFS_STACK_PTR    = 8'h0c;
   localparam logic [7:0] PCRS_OFS_TOP_LOW      = 8'h10;
   localparam logic [7:0] PCRS_OFS_TOP_HIGH     = 8'h14;
   localparam logic [7:0] PCRS_OFS_TOP_UPPER    = 8'h18;
   localparam logic [7:0] PCRS_OFS_CONTROL      = 8'h1c;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int PCRS_FULL_BIT = 7;   // stack_full_flag
   localparam int PCRS_UNF_BIT  = 6;   // stack_underflow_flag
   localparam int PCRS_OVR_BIT  = 0;   // overflow_reset_enable in control
   localparam logic [7:0] PCRS_PTR_REG_RST = 8'h00;
   localparam logic [7:0] PCRS_CTL_RST     = 8'h01;
   localparam logic [7:0] PCRS_LATCH_RST   = 8'h00;
   localparam logic [7:0] PCRS_SHADOW_RST  = 8'h00;
   // ------------------------------------------------------------
   // counter values
   // ------------------------------------------------------------
   localparam logic [20:0] PCRS_VEC_RESET = 21'h000000;
   localparam logic [20:0] PCRS_VEC_HIGH  = 21'h000008;
   localparam logic [20:0] PCRS_VEC_LOW   = 21'h000018;
   localparam logic [20:0] PCRS_PC_STEP   = 21'h000002;
   localparam logic [4:0]  PCRS_PTR_EMPTY = 5'h00;
   localparam logic [4:0]  PCRS_PTR_LAST  = 5'h1f;
   localparam logic [4:0]  PCRS_PTR_FILL  = 5'h1e;  // pointer before 31st push
   // ------------------------------------------------------------
   // bus answers
   // ------------------------------------------------------------
   localparam logic [1:0] PCRS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PCRS_RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // sequencer commands and carriers
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      PCRS_CMD_STEP = 7'h01,  // sequential advance
      PCRS_CMD_JUMP = 7'h02,  // goto or branch
      PCRS_CMD_CALL = 7'h04,  // call or relative_call
      PCRS_CMD_RET  = 7'h08,  // return, return_with_literal, return_from_interrupt
      PCRS_CMD_IRQ  = 7'h10,  // interrupt acknowledge
      PCRS_CMD_PUSH = 7'h20,  // software push
      PCRS_CMD_POP  = 7'h40   // software pop
   } pcrs_cmd_t;
   typedef struct packed {
      pcrs_cmd_t   cmd;        // what the instruction does
      logic        fast;       // fast option on call or return
      logic        irq_high;   // high priority vector on acknowledge
      logic [20:0] target;     // absolute destination for jump or call
      logic [7:0]  status;     // live status register
      logic [7:0]  working_register;       // live working_register
      logic [7:0]  bank_select_register;        // live bank_select_register
   } pcrs_seq_req_t;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] working_register;
      logic [7:0] bank_select_register;
   } pcrs_shadow_t;
endpackage

// [logic/pcrs_core.sv]
// program counter, return stack, fast shadows and their register slave
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pcrs_core
   import pcrs_pkg::*;
(
   input  wire logic          mclk_in,            // core clock
   input  wire logic          srst_in,            // power-on reset
   input  wire logic          warm_rst_in,        // any other device reset
   input  wire logic          seq_valid_in,       // sequencer command strobe
   input  wire pcrs_seq_req_t seq_req_in,         // sequencer command
   output logic [20:0]        pc_out,             // next fetch address
   output logic               restore_valid_out,  // shadows being restored
   output pcrs_shadow_t       restore_out,        // restored values
   output logic               dev_reset_req_out,  // stack fault reset request
   input  wire logic [7:0]    awaddr_in,
   input  wire logic          awvalid_in,
   output logic               awready_out,
   input  wire logic [31:0]   wdata_in,
   input  wire logic [3:0]    wstrb_in,
   input  wire logic          wvalid_in,
   output logic               wready_out,
   output logic [1:0]         bresp_out,
   output logic               bvalid_out,
   input  wire logic          bready_in,
   input  wire logic [7:0]    araddr_in,
   input  wire logic          arvalid_in,
   output logic               arready_out,
   output logic [31:0]        rdata_out,
   output logic [1:0]         rresp_out,
   output logic               rvalid_out,
   input  wire logic          rready_in
);
   // ------------------------------------------------------------
   // register select
   // ------------------------------------------------------------
   function automatic logic [3:0] pcrs_sel(input logic [7:0] a);
      case (a)
         PCRS_OFS_COUNTER_LOW: pcrs_sel = 4'h0;
         PCRS_OFS_HIGH_LATCH:  pcrs_sel = 4'h1;
         PCRS_OFS_UPPER_LATCH: pcrs_sel = 4'h2;
         PCRS_OFS_STACK_PTR:   pcrs_sel = 4'h3;
         PCRS_OFS_TOP_LOW:     pcrs_sel = 4'h4;
         PCRS_OFS_TOP_HIGH:    pcrs_sel = 4'h5;
         PCRS_OFS_TOP_UPPER:   pcrs_sel = 4'h6;
         PCRS_OFS_CONTROL:     pcrs_sel = 4'h7;
         default:              pcrs_sel = 4'hf;  // unmapped
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // state moves only on the rising clock
   logic [20:0]  pc;                            // program counter
   logic [7:0]   counter_high_latch;            // staged bits 15:8
   logic [4:0]   counter_upper_latch;           // staged bits 20:16
   logic [4:0]   stack_ptr;                     // return stack pointer
   logic         stack_full_flag;               // sticky full
   logic         stack_underflow_flag;          // sticky underflow
   logic         overflow_reset_enable;         // stack fault resets device
   logic [20:0]  stack_mem [1:PCRS_DEPTH];      // return storage
   pcrs_shadow_t shadow;                        // one-level fast stack
   logic         aw_hold;                       // write address captured
   logic         w_hold;                        // write data captured
   logic [7:0]   aw_addr;                       // captured address
   logic [7:0]   w_byte;                        // captured low byte
   logic         w_lane0;                       // low lane enabled

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic        wr_fire;      // register write takes effect
   logic        rd_fire;      // register read takes effect
   logic [3:0]  wr_sel;       // write target
   logic [3:0]  rd_sel;       // read target
   logic        wr_en;        // write with low lane
   logic        is_push;      // command pushes
   logic        is_pop;       // command pops
   logic        set_full;     // push at or past the 31st
   logic        set_unf;      // pop from empty
   logic        trip;         // stack fault reset
   logic        any_rst;      // power-on or warm reset in force
   logic [20:0] top;          // entry under pointer
   logic [20:0] push_val;     // value to store on push

   // software access waits for a cycle with no sequencer command,
   // so core updates and register writes never collide
   assign wr_fire = aw_hold & w_hold & ~bvalid_out & ~seq_valid_in;
   assign rd_fire = arvalid_in & arready_out;
   assign wr_sel  = pcrs_sel(aw_addr);
   assign rd_sel  = pcrs_sel(araddr_in);
   assign wr_en   = wr_fire & w_lane0;
   assign any_rst = srst_in | warm_rst_in;

   // command classes
   always_comb begin
      is_push = 1'b0;
      is_pop  = 1'b0;
      if (seq_valid_in) begin
         case (seq_req_in.cmd)
            PCRS_CMD_CALL, PCRS_CMD_IRQ, PCRS_CMD_PUSH: is_push = 1'b1;
            PCRS_CMD_RET, PCRS_CMD_POP:                 is_pop  = 1'b1;
            default: begin
               is_push = 1'b0;
               is_pop  = 1'b0;
            end
         endcase
      end
   end

   // faults judge the pointer before this edge
   // pointer zero has no storage and reads as zero
   assign top      = (stack_ptr == PCRS_PTR_EMPTY) ? 21'h000000 : stack_mem[stack_ptr];
   assign set_full = is_push & (stack_ptr >= PCRS_PTR_FILL) & ~warm_rst_in;
   assign set_unf  = is_pop & (stack_ptr == PCRS_PTR_EMPTY) & ~warm_rst_in;
   assign trip     = overflow_reset_enable & (set_full | set_unf);
   // the 31st push under the reset option stores the step-ahead address
   assign push_val = (overflow_reset_enable && stack_ptr == PCRS_PTR_FILL) ?
                     21'(pc + PCRS_PC_STEP) : pc;

   // ------------------------------------------------------------
   // program counter
   // ------------------------------------------------------------
   // resets and faults beat commands and writes
   always_ff @(posedge mclk_in) begin
      if (any_rst || trip) begin
         pc <= PCRS_VEC_RESET;
      end else if (seq_valid_in) begin
         case (seq_req_in.cmd)
            PCRS_CMD_STEP: pc <= 21'(pc + PCRS_PC_STEP);
            // direct load, latches not involved
            PCRS_CMD_JUMP, PCRS_CMD_CALL: pc <= {seq_req_in.target[20:1], 1'b0};
            PCRS_CMD_IRQ: pc <= seq_req_in.irq_high ? PCRS_VEC_HIGH : PCRS_VEC_LOW;
            // empty pop yields zero via top
            PCRS_CMD_RET: pc <= {top[20:1], 1'b0};
            default: pc <= pc;  // software push and pop keep flow
         endcase
      end else if (wr_en && wr_sel == 4'h0) begin
         pc <= {counter_upper_latch, counter_high_latch, w_byte[7:1], 1'b0};
      end
   end
   assign pc_out = pc;

   // ------------------------------------------------------------
   // high and upper latches
   // ------------------------------------------------------------
   // calls and returns never touch these
   // a bus write beats a counter-low read
   always_ff @(posedge mclk_in) begin
      if (any_rst) begin
         counter_high_latch  <= PCRS_LATCH_RST;
         counter_upper_latch <= PCRS_LATCH_RST[4:0];
      end else if (wr_en && wr_sel == 4'h1) begin
         counter_high_latch <= w_byte;
      end else if (wr_en && wr_sel == 4'h2) begin
         counter_upper_latch <= w_byte[4:0];
      end else if (rd_fire && rd_sel == 4'h0) begin
         counter_high_latch  <= pc[15:8];
         counter_upper_latch <= pc[20:16];
      end
   end

   // ------------------------------------------------------------
   // stack pointer
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (any_rst || trip) begin
         stack_ptr <= PCRS_PTR_EMPTY;
      end else if (is_push) begin
         // held at 31 once full, extra pushes are dropped
         if (stack_ptr != PCRS_PTR_LAST)
            stack_ptr <= 5'(stack_ptr + 5'h01);
      end else if (is_pop) begin
         // stays at zero on underflow
         if (stack_ptr != PCRS_PTR_EMPTY)
            stack_ptr <= 5'(stack_ptr - 5'h01);
      // bus writes land only in idle cycles
      end else if (wr_en && wr_sel == 4'h3) begin
         stack_ptr <= w_byte[4:0];
      end
   end

   // ------------------------------------------------------------
   // sticky flags, cleared by software or power-on only
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         stack_full_flag      <= PCRS_PTR_REG_RST[PCRS_FULL_BIT];
         stack_underflow_flag <= PCRS_PTR_REG_RST[PCRS_UNF_BIT];
      end else begin
         // warm resets leave both flags set
         // a set in the clearing cycle wins; writing one has no effect
         stack_full_flag <= set_full |
            (stack_full_flag & ~(wr_en && wr_sel == 4'h3 && !w_byte[PCRS_FULL_BIT]));
         stack_underflow_flag <= set_unf |
            (stack_underflow_flag & ~(wr_en && wr_sel == 4'h3 && !w_byte[PCRS_UNF_BIT]));
      end
   end

   // ------------------------------------------------------------
   // return storage
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      // no reset on the array itself
      if (!any_rst) begin
         if (is_push && stack_ptr != PCRS_PTR_LAST) begin
            // new entry is one above the current pointer
            stack_mem[5'(stack_ptr + 5'h01)] <= push_val;
         end else if (wr_en && stack_ptr != PCRS_PTR_EMPTY) begin
            // top registers patch the pointed entry bytewise
            case (wr_sel)
               4'h4:    stack_mem[stack_ptr][7:0]   <= w_byte;
               4'h5:    stack_mem[stack_ptr][15:8]  <= w_byte;
               4'h6:    stack_mem[stack_ptr][20:16] <= w_byte[4:0];
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // overflow reset option and fault reset request
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      // warm resets keep the option
      if (srst_in)
         overflow_reset_enable <= PCRS_CTL_RST[PCRS_OVR_BIT];
      else if (wr_en && wr_sel == 4'h7)
         overflow_reset_enable <= w_byte[PCRS_OVR_BIT];
   end

   // one-cycle pulse after a fault with the option on
   always_ff @(posedge mclk_in) begin
      if (any_rst)
         dev_reset_req_out <= 1'b0;
      else
         dev_reset_req_out <= trip;
   end

   // ------------------------------------------------------------
   // fast shadow stack
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         shadow <= {PCRS_SHADOW_RST, PCRS_SHADOW_RST, PCRS_SHADOW_RST};
      end else if (seq_valid_in && (seq_req_in.cmd == PCRS_CMD_IRQ ||
                   (seq_req_in.cmd == PCRS_CMD_CALL && seq_req_in.fast))) begin
         // one level: later capture overwrites
         shadow.status <= seq_req_in.status;
         shadow.working_register   <= seq_req_in.working_register;
         shadow.bank_select_register    <= seq_req_in.bank_select_register;
      end
   end

   // restore strobe with the saved values
   always_ff @(posedge mclk_in) begin
      if (any_rst) begin
         restore_valid_out <= 1'b0;
         restore_out       <= {PCRS_SHADOW_RST, PCRS_SHADOW_RST, PCRS_SHADOW_RST};
      end else begin
         restore_valid_out <= seq_valid_in && seq_req_in.cmd == PCRS_CMD_RET
                              && seq_req_in.fast;
         restore_out       <= shadow;
      end
   end

   // ------------------------------------------------------------
   // register bus, write side
   // ------------------------------------------------------------
   // each half refused while its copy waits
   assign awready_out = ~aw_hold;
   assign wready_out  = ~w_hold;

   // address and data may arrive in either order
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         aw_hold <= 1'b0;
         aw_addr <= 8'h00;
      end else if (awvalid_in && !aw_hold) begin
         aw_hold <= 1'b1;
         aw_addr <= awaddr_in;
      end else if (wr_fire) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         w_hold  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (wvalid_in && !w_hold) begin
         w_hold  <= 1'b1;
         w_byte  <= wdata_in[7:0];
         w_lane0 <= wstrb_in[0];
      end else if (wr_fire) begin
         w_hold <= 1'b0;
      end
   end

   // response after the write, error for unmapped
   // response stands until bready is high
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         bvalid_out <= 1'b0;
         bresp_out  <= PCRS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_out <= 1'b1;
         bresp_out  <= (wr_sel == 4'hf) ? PCRS_RESP_SLVERR : PCRS_RESP_OKAY;
      end else if (bready_in) begin
         bvalid_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register bus, read side
   // ------------------------------------------------------------
   // no read while a command moves the pointer
   assign arready_out = ~rvalid_out & ~seq_valid_in;

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rvalid_out <= 1'b0;
         rresp_out  <= PCRS_RESP_OKAY;
         rdata_out  <= 32'h00000000;
      end else if (rd_fire) begin
         // payload stands until rready
         rvalid_out <= 1'b1;
         rresp_out  <= (rd_sel == 4'hf) ? PCRS_RESP_SLVERR : PCRS_RESP_OKAY;
         case (rd_sel)
            4'h0:    rdata_out <= {24'h000000, pc[7:0]};
            4'h1:    rdata_out <= {24'h000000, counter_high_latch};
            4'h2:    rdata_out <= {27'h0000000, counter_upper_latch};
            4'h3:    rdata_out <= {24'h000000, stack_full_flag, stack_underflow_flag,
                                   1'b0, stack_ptr};
            4'h4:    rdata_out <= {24'h000000, top[7:0]};
            4'h5:    rdata_out <= {24'h000000, top[15:8]};
            4'h6:    rdata_out <= {27'h0000000, top[20:16]};
            4'h7:    rdata_out <= {31'h00000000, overflow_reset_enable};
            default: rdata_out <= 32'h00000000;
         endcase
      end else if (rready_in) begin
         rvalid_out <= 1'b0;
      end
   end
endmodule

// [testbench/pcrs_seq_src.sv]
// sequencer stand-in: turns bench requests into executed commands
`timescale 1ns/1ps
module pcrs_seq_src import pcrs_pkg::*; (
   input  wire logic          mclk_in,        // core clock
   input  wire logic          go_in,          // bench asks for one command
   input  wire pcrs_seq_req_t req_in,         // command to issue
   output logic               seq_valid_out,  // one executed command this cycle
   output pcrs_seq_req_t      seq_req_out     // command, scrambled while idle
);
   // ------------------------------------------------------------
   // issue
   // ------------------------------------------------------------
   // commands follow go_in alone; the core defers register access to cycles without one, so no vectoring
   // can disturb the pointed entry during top access; idle payload inverted
   always_ff @(posedge mclk_in) begin
      seq_valid_out <= go_in;
      seq_req_out   <= go_in ? req_in : pcrs_seq_req_t'(~req_in);
   end
endmodule

// [testbench/pcrs_core_sva.sv]
// port checks for the program counter and return stack
`timescale 1ns/1ps
module pcrs_core_sva import pcrs_pkg::*; (
   input wire logic          mclk_in,
   input wire logic          srst_in,
   input wire logic          warm_rst_in,
   input wire logic          seq_valid_in,
   input wire pcrs_seq_req_t seq_req_in,
   input wire logic [20:0]   pc_out,
   input wire logic          restore_valid_out,
   input wire logic          dev_reset_req_out,
   input wire logic          rvalid_out
);
   logic [6:0]  live;   // command taken at this edge, zero if none
   logic [20:0] tgt_q;  // target seen at the previous edge
   assign live = (seq_valid_in && !warm_rst_in) ? seq_req_in.cmd : 7'h00;
   always_ff @(posedge mclk_in) tgt_q <= seq_req_in.target;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   AST_STEP: assert property (live == PCRS_CMD_STEP |=> pc_out == $past(pc_out) + 21'h000002)
      else $error("step not by two");
   AST_ALIGN: assert property (seq_valid_in |=> !pc_out[0])
      else $error("odd counter");
   AST_JUMP: assert property (live == PCRS_CMD_JUMP |=> pc_out == {tgt_q[20:1], 1'b0})
      else $error("jump target lost");
   AST_IRQ_HI: assert property (live == PCRS_CMD_IRQ && seq_req_in.irq_high
      |=> pc_out == PCRS_VEC_HIGH || dev_reset_req_out) else $error("high vector");
   AST_IRQ_LO: assert property (live == PCRS_CMD_IRQ && !seq_req_in.irq_high
      |=> pc_out == PCRS_VEC_LOW || dev_reset_req_out) else $error("low vector");
   AST_FAST_RET: assert property (live == PCRS_CMD_RET && seq_req_in.fast |=> restore_valid_out)
      else $error("no restore");
   AST_NO_RESTORE: assert property (!(seq_valid_in && seq_req_in.cmd == PCRS_CMD_RET && seq_req_in.fast)
      |=> !restore_valid_out) else $error("stray restore");
   AST_FAULT_PC: assert property (dev_reset_req_out |-> pc_out == 21'h000000)
      else $error("fault kept counter");
   AST_WARM: assert property (warm_rst_in |=> pc_out == 21'h000000)
      else $error("warm reset kept counter");
   AST_POR: assert property (disable iff (1'b0) srst_in |=> pc_out == 21'h000000 && !rvalid_out)
      else $error("reset state wrong");
   COV_FULL: cover property (live == PCRS_CMD_CALL ##1 dev_reset_req_out);
   COV_IRQ: cover property (live == PCRS_CMD_IRQ);
   COV_RESTORE: cover property (restore_valid_out);
endmodule
bind pcrs_core pcrs_core_sva u_sva (.mclk_in, .srst_in, .warm_rst_in, .seq_valid_in, .seq_req_in, .pc_out,
   .restore_valid_out, .dev_reset_req_out, .rvalid_out);

// [testbench/tb.sv]
// bench: integer model of counter and stack compared with the core
`timescale 1ns/1ps
module tb import pcrs_pkg::*; ;
   logic mclk_in = 1'b0, srst_in = 1'b1, warm_rst_in = 1'b0, go = 1'b0;
   logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
   logic seq_valid_in, restore_valid_out, dev_reset_req_out, awready_out, wready_out, bvalid_out;
   logic arready_out, rvalid_out;
   logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0, rdata_out;
   logic [1:0] bresp_out, rresp_out;
   logic [20:0] pc_out;
   pcrs_seq_req_t req = '0, seq_req_in;
   pcrs_shadow_t restore_out;
   logic [23:0] shd = 24'h0;                                 // model fast shadow
   int n_fail = 0, num_checks = 0, cyc = 0, seed = 32'hac64;
   int pc = 0, ptr = 0, full = 0, unf = 0, opt = 1, stk[32]; // model state
   pcrs_seq_src u_src (.mclk_in, .go_in(go), .req_in(req), .seq_valid_out(seq_valid_in), .seq_req_out(seq_req_in));
   pcrs_core dut (.mclk_in, .srst_in, .warm_rst_in, .seq_valid_in, .seq_req_in, .pc_out, .restore_valid_out,
      .restore_out, .dev_reset_req_out, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in(4'hf),
      .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
      .rdata_out, .rresp_out, .rvalid_out, .rready_in);
   initial forever #2.5 mclk_in = ~mclk_in;
   // hang guard
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // bus write: address and data offered together, each released when taken
   task automatic bwr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = PCRS_RESP_OKAY);
      bit ta, tw;
      @(posedge mclk_in);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         ta = awready_out && awvalid_in;
         tw = wready_out && wvalid_in;
         @(posedge mclk_in);
         awvalid_in <= awvalid_in && !ta;
         wvalid_in <= wvalid_in && !tw;
      end while ((awvalid_in && !ta) || (wvalid_in && !tw));
      do @(negedge mclk_in); while (!bvalid_out);
      chk(bresp_out, er);
      @(posedge mclk_in);
      bready_in <= 1'b0;
   endtask
   // bus read with data and response compare
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = PCRS_RESP_OKAY);
      @(posedge mclk_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do @(negedge mclk_in); while (!arready_out);
      @(posedge mclk_in);
      arvalid_in <= 1'b0;
      do @(negedge mclk_in); while (!rvalid_out);
      chk(rdata_out, e);
      chk(rresp_out, er);
      @(posedge mclk_in);
      rready_in <= 1'b0;
   endtask
   // one command through the sequencer, model updated alongside
   task automatic run(input int k, input bit f, input bit h, input logic [20:0] t);
      logic [23:0] sh;
      int nx;
      bit ps, pp, dr, r;
      sh = 24'($random(seed));
      @(posedge mclk_in);
      req <= pcrs_seq_req_t'({7'h01 << k, f, h, t, sh});
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      ps = k == 2 || k == 4 || k == 5;
      pp = k == 3 || k == 6;
      nx = (k == 1 || k == 2) ? t & 'h1ffffe : (k == 4) ? (h ? 'h8 : 'h18) : (k == 0) ? (pc + 2) & 'h1ffffe : pc;
      dr = opt && ((ps && ptr >= 30) || (pp && ptr == 0));
      r = dr || (k == 3 && ptr == 0);
      if (k == 4 || (k == 2 && f)) shd = sh;
      if (ps && ptr >= 30) full = 1;
      if (pp && ptr == 0) unf = 1;
      if (k == 3 && ptr > 0) nx = stk[ptr];
      if (pp && ptr > 0) ptr--;
      if (ps && ptr < 31) begin
         ptr++;
         stk[ptr] = dr ? pc + 2 & 'h1fffff : pc;
      end
      pc = r ? 0 : nx;
      if (dr) ptr = 0;
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk(pc_out, pc);
      chk(dev_reset_req_out, dr);
      chk(restore_valid_out, k == 3 && f);
      if (k == 3 && f) chk(restore_out, shd);
   endtask
   task automatic rnd(input int n);
      for (int i = 0; i < n; i++) begin
         run($unsigned($random(seed)) % 7, 1'($random(seed)), 1'($random(seed)), 21'($random(seed)));
         if (i % 16 == 15) rdc(PCRS_OFS_STACK_PTR, full * 128 + unf * 64 + ptr);
      end
   endtask
   initial begin
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'b0;
      rdc(PCRS_OFS_CONTROL, 32'h1);
      rdc(PCRS_OFS_STACK_PTR, 32'h0);
      rdc(8'h20, 32'h0, PCRS_RESP_SLVERR);
      bwr(8'h24, 0, PCRS_RESP_SLVERR);
      bwr(PCRS_OFS_HIGH_LATCH, 32'h12);
      bwr(PCRS_OFS_UPPER_LATCH, 32'h05);
      bwr(PCRS_OFS_COUNTER_LOW, 32'h35);
      @(negedge mclk_in);
      chk(pc_out, 21'h051234);
      run(1, 0, 0, 21'h0abcdf);
      run(2, 1, 0, 21'h00f0f1);
      run(3, 1, 0, 21'h0);
      rdc(PCRS_OFS_HIGH_LATCH, 32'h12);
      rdc(PCRS_OFS_COUNTER_LOW, pc & 'hff);
      rdc(PCRS_OFS_HIGH_LATCH, pc >> 8 & 'hff);
      rdc(PCRS_OFS_UPPER_LATCH, pc >> 16);
      $display("latch test done");
      repeat (31) run(2, 0, 0, 21'($random(seed)));
      rdc(PCRS_OFS_STACK_PTR, 32'h80);
      bwr(PCRS_OFS_STACK_PTR, 32'h9f);
      ptr = 31;
      rdc(PCRS_OFS_TOP_LOW, stk[31] & 'hff);
      rnd(250);
      $display("overflow reset test done");
      bwr(PCRS_OFS_CONTROL, 32'h0);
      bwr(PCRS_OFS_STACK_PTR, 32'h0);
      {opt, full, unf, ptr} = '0;
      repeat (33) run(2, 0, 0, 21'($random(seed)));
      rdc(PCRS_OFS_STACK_PTR, 32'h9f);
      rnd(250);
      $display("no reset test done");
      bwr(PCRS_OFS_STACK_PTR, 32'h02);
      bwr(PCRS_OFS_TOP_LOW, 32'h56);
      bwr(PCRS_OFS_TOP_HIGH, 32'h34);
      bwr(PCRS_OFS_TOP_UPPER, 32'h01);
      rdc(PCRS_OFS_TOP_HIGH, 32'h34);
      {full, unf, ptr, stk[2]} = {32'd0, 32'd0, 32'd2, 32'h013456};
      repeat (3) run(3 + 3 * (ptr == 0), 0, 0, 21'h0);
      $display("top access test done");
      @(posedge mclk_in);
      warm_rst_in <= 1'b1;
      @(posedge mclk_in);
      warm_rst_in <= 1'b0;
      {pc, ptr} = '0;
      @(negedge mclk_in);
      chk(pc_out, 21'h0);
      rdc(PCRS_OFS_STACK_PTR, full * 128 + unf * 64);
      rdc(PCRS_OFS_HIGH_LATCH, 32'h0);
      $display("warm reset test done");
      give_verdict();
   end
endmodule
